// ### cmd_bus_if.sv
// decoded command carried from the decoder to the state tracker
`timescale 1ns/10ps
interface cmd_bus_if;
  import cmd_decode_pkg::*;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [ADDR_W-1:0] addr;
  cmd_t cmd;
  modport decoder (input cs_n, input ras_n, input cas_n, input we_n, input addr, output cmd);
  modport user (output cs_n, output ras_n, output cas_n, output we_n, output addr, input cmd);
endinterface : cmd_bus_if

// ### cmd_decode_pkg.sv
// shared constants and types for the sdram command decoder
package cmd_decode_pkg;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 16;
  localparam int MR_COUNT = 4;
  localparam int MR_SEL_W = 2;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int MR0_BL_LO = 0;
  localparam int MR0_BL_HI = 1;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_PER_CMD = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [3:0] BURST_LEN8 = 4'h8;
  localparam logic [3:0] BURST_LEN4 = 4'h4;
  localparam logic [ADDR_W-1:0] MR_RESET = 16'h0000;

  typedef enum logic [4:0] {
    cmd_deselect,
    cmd_nop,
    cmd_mode_register_write,
    cmd_refresh,
    cmd_self_refresh_enter,
    cmd_self_refresh_leave,
    cmd_precharge_one,
    cmd_precharge_every_bank,
    cmd_activate,
    cmd_write,
    cmd_read,
    cmd_power_down_enter,
    cmd_power_down_leave,
    cmd_long_impedance_calibration,
    cmd_short_impedance_calibration,
    cmd_illegal
  } cmd_t;

  typedef enum logic [1:0] {
    st_active,
    st_power_down,
    st_self_refresh
  } pwr_state_t;
endpackage : cmd_decode_pkg

// ### ctl_model.sv
// memory controller model that drives the command and address pins
`timescale 1ns/10ps
module ctl_model
  import cmd_decode_pkg::*;
(
  input wire logic clk, // controller clock
  output logic cke, // clock enable
  output logic cs_n, // chip select, active low
  output logic ras_n, // row strobe, active low
  output logic cas_n, // column strobe, active low
  output logic we_n, // write enable, active low
  output logic [BANK_W-1:0] ba, // bank address
  output logic [ADDR_W-1:0] addr, // address / opcode
  output logic odt // termination, wanders freely
);
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h0f;
    ba = '0;
    addr = '0;
  end
  // odt keeps toggling so any leak into decode shows up
  initial begin
    odt = 1'b0;
    forever @(negedge clk) odt = ~odt;
  end
  // one command a cycle; pins hold until the next call
  task automatic send(input logic [3:0] pins, input logic k = 1'b1,
                      input logic [BANK_W-1:0] b = '0, input logic [ADDR_W-1:0] a = '0);
    @(negedge clk);
    cke = k;
    cs_n = pins[3];
    if (pins[3]) begin
      // deselected: other lines are don't-care, so they wander
      {ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
      ba = ~ba;
      addr = ~addr;
    end else begin
      {ras_n, cas_n, we_n} = pins[2:0];
      ba = b;
      addr = a;
    end
    @(posedge clk);
    #1;
  endtask : send
endmodule : ctl_model

// ### sdram_command_decoder.sv
// command decode and clock-enable state tracking for a ddr sdram
// Overview of operation
// - commands come only from strobe, cke and address bit 10 levels at the rising clock edge
// - reset pin is a synchronous reset only; held high in normal use
// - on-die termination input never affects decode or power state
// - mode register write: bank address picks one of four mode registers
// - self refresh exit follows the cke level at the clock edge, not a registered cke rise
// - a started read or write burst always runs to its end
// - fixed or per-command burst length follows mode register zero
// - a no-operation registers nothing and leaves running work alone
// - chip select high ignores other inputs, acts as no-operation
// - deselect and no-operation have the same effect
// - no refresh in power-down; controller must exit in time
// - first long calibration after start is initial, later ones operational
// - cke changes judged on state before edge n, cke n versus n-1
// - idle means banks closed, no burst, cke high
`timescale 1ns/10ps
module sdram_command_decoder
  import cmd_decode_pkg::*;
(
  input wire logic clk, // controller clock
  input wire logic rst_n, // device reset, active low
  input wire logic cke, // clock enable
  input wire logic cs_n, // chip select, active low
  input wire logic ras_n, // row strobe, active low
  input wire logic cas_n, // column strobe, active low
  input wire logic we_n, // write enable, active low
  input wire logic [BANK_W-1:0] ba, // bank address
  input wire logic [ADDR_W-1:0] addr, // address / opcode
  input wire logic odt, // on-die termination, not used by decode
  output logic [4:0] cmd_code, // registered command code
  output logic cmd_valid, // registered command pulse
  output logic [BANK_W-1:0] cmd_bank, // registered bank
  output logic [ADDR_W-1:0] cmd_addr, // registered address
  output logic cmd_auto_close, // read/write with auto precharge
  output logic [3:0] cmd_burst_len, // burst length of read/write
  output logic [1:0] pwr_state, // power state code
  output logic [ADDR_W-1:0] mode_reg [MR_COUNT], // mode registers
  output logic [BANK_W:0] open_banks, // count of open banks
  output logic burst_busy, // a burst is running
  output logic idle, // all banks idle, cke high
  output logic cal_initial, // long calibration was the initial one
  output logic cal_pulse // long or short calibration pulse
);
  cmd_bus_if bus ();
  pwr_state_t pwr_r, pwr_nxt;
  logic cke_prev_r;
  logic [ADDR_W-1:0] mr_r [MR_COUNT];
  logic [(1<<BANK_W)-1:0] open_r;
  logic [3:0] burst_cnt_r, burst_cnt_nxt;
  logic zq_seen_r;
  logic [4:0] code_r;
  logic valid_r, ap_r, cal_init_r, cal_pulse_r;
  logic [3:0] blen_r;
  logic [BANK_W-1:0] bank_r;
  logic [ADDR_W-1:0] addr_r;

  function automatic logic [3:0] burst_len(input logic [ADDR_W-1:0] mr0,
                                           input logic a12);
    logic [1:0] mode;
    mode = mr0[MR0_BL_HI:MR0_BL_LO];
    case (mode)
      BL_FIXED8: burst_len = BURST_LEN8;
      BL_PER_CMD: burst_len = a12 ? BURST_LEN8 : BURST_LEN4;
      BL_FIXED4: burst_len = BURST_LEN4;
      default: burst_len = BURST_LEN8;
    endcase
  endfunction : burst_len

  // odt is deliberately left out of every expression
  assign bus.cs_n = cs_n;
  assign bus.ras_n = ras_n;
  assign bus.cas_n = cas_n;
  assign bus.we_n = we_n;
  assign bus.addr = addr;

  strobe_decoder u_dec (
    .bus(bus)
  );

  wire [MR_SEL_W-1:0] mr_sel = ba[MR_SEL_W-1:0];
  wire awake = (pwr_r == st_active);
  wire nop_like = (bus.cmd == cmd_deselect) || (bus.cmd == cmd_nop);
  wire all_idle = (open_r == '0) && (burst_cnt_r == 4'h0);
  wire cke_rise = !cke_prev_r && cke;
  wire cke_fall = cke_prev_r && !cke;
  wire sr_enter = awake && cke_fall && all_idle && (bus.cmd == cmd_refresh);
  wire pd_enter = awake && cke_fall && nop_like;
  // self refresh exit follows the cke level directly, no clocked wait
  wire sr_leave = (pwr_r == st_self_refresh) && cke && nop_like;
  wire pd_leave = (pwr_r == st_power_down) && cke_rise && nop_like;
  // nothing executes in power-down, refresh included
  wire exec = awake && cke && cke_prev_r;
  wire is_rw = (bus.cmd == cmd_read) || (bus.cmd == cmd_write);
  // a new burst only starts once the previous one ended; never truncated
  wire rw_go = exec && is_rw && (burst_cnt_r == 4'h0);
  wire [3:0] blen = burst_len(mr_r[0], addr[BC_BIT]);
  wire [4:0] dec_code = sr_enter ? 5'(cmd_self_refresh_enter)
                      : pd_enter ? 5'(cmd_power_down_enter)
                      : sr_leave ? 5'(cmd_self_refresh_leave)
                      : pd_leave ? 5'(cmd_power_down_leave)
                      : 5'(bus.cmd);
  wire accept = sr_enter || pd_enter || sr_leave || pd_leave ||
                (exec && !nop_like && bus.cmd != cmd_illegal &&
                 (!is_rw || rw_go));
  wire is_long_cal = exec && bus.cmd == cmd_long_impedance_calibration;

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      st_active: begin
        if (sr_enter) pwr_nxt = st_self_refresh;
        else if (pd_enter) pwr_nxt = st_power_down;
      end
      st_power_down: if (pd_leave) pwr_nxt = st_active;
      st_self_refresh: if (sr_leave) pwr_nxt = st_active;
      default: pwr_nxt = st_active;
    endcase
  end

  assign burst_cnt_nxt = rw_go ? blen : (burst_cnt_r != 4'h0) ? burst_cnt_r - 4'h1 : 4'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_r <= st_active;
      cke_prev_r <= 1'b0;
      burst_cnt_r <= 4'h0;
    end else begin
      pwr_r <= pwr_nxt;
      cke_prev_r <= cke;
      burst_cnt_r <= burst_cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < MR_COUNT; i++) mr_r[i] <= MR_RESET;
    end else if (exec && bus.cmd == cmd_mode_register_write) begin
      mr_r[mr_sel] <= addr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      open_r <= '0;
    end else if (exec) begin
      case (bus.cmd)
        cmd_activate: open_r[ba] <= 1'b1;
        cmd_precharge_one: open_r[ba] <= 1'b0;
        cmd_precharge_every_bank: open_r <= '0;
        default: if (rw_go && addr[AP_BIT]) open_r[ba] <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zq_seen_r <= 1'b0;
      cal_init_r <= 1'b0;
      cal_pulse_r <= 1'b0;
    end else begin
      cal_pulse_r <= exec && (bus.cmd == cmd_long_impedance_calibration ||
                              bus.cmd == cmd_short_impedance_calibration);
      if (is_long_cal) begin
        cal_init_r <= !zq_seen_r;
        zq_seen_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_r <= 5'(cmd_deselect);
      valid_r <= 1'b0;
      bank_r <= '0;
      addr_r <= '0;
      ap_r <= 1'b0;
      blen_r <= 4'h0;
    end else begin
      code_r <= dec_code;
      valid_r <= accept;
      bank_r <= ba;
      addr_r <= addr;
      ap_r <= is_rw && addr[AP_BIT];
      blen_r <= is_rw ? blen : 4'h0;
    end
  end

  assign cmd_code = code_r;
  assign cmd_valid = valid_r;
  assign cmd_bank = bank_r;
  assign cmd_addr = addr_r;
  assign cmd_auto_close = ap_r;
  assign cmd_burst_len = blen_r;
  assign pwr_state = pwr_r;
  assign mode_reg = mr_r;
  assign open_banks = (BANK_W+1)'($countones(open_r));
  assign burst_busy = (burst_cnt_r != 4'h0);
  assign idle = awake && cke_prev_r && all_idle;
  assign cal_initial = cal_init_r;
  assign cal_pulse = cal_pulse_r;

  property p_pd_entry;
    @(posedge clk) disable iff (!rst_n) pd_enter && !sr_enter |=> pwr_r == st_power_down;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

  property p_sr_entry;
    @(posedge clk) disable iff (!rst_n) sr_enter |=> pwr_r == st_self_refresh;
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("self refresh not entered");

  property p_hold_low;
    @(posedge clk) disable iff (!rst_n) (pwr_r != st_active) && !cke |=> pwr_r == $past(pwr_r);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("low power state lost");

  property p_burst_run;
    @(posedge clk) disable iff (!rst_n) rw_go |=> burst_cnt_r == $past(blen);
  endproperty
  a_burst_run: assert property (p_burst_run) else $error("burst length wrong");

  property p_no_interrupt;
    @(posedge clk) disable iff (!rst_n) burst_cnt_r > 4'h1 |=> burst_cnt_r == $past(burst_cnt_r) - 4'h1;
  endproperty
  a_no_interrupt: assert property (p_no_interrupt) else $error("burst interrupted");

  property p_mr_write;
    @(posedge clk) disable iff (!rst_n) exec && bus.cmd == cmd_mode_register_write
      |=> mr_r[$past(mr_sel)] == $past(addr);
  endproperty
  a_mr_write: assert property (p_mr_write) else $error("mode register not written");

  property p_nop_quiet;
    @(posedge clk) disable iff (!rst_n) awake && cke && cke_prev_r && nop_like |=> !valid_r;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("nop registered a command");

  property p_zq_first;
    @(posedge clk) disable iff (!rst_n) is_long_cal && zq_seen_r |=> !cal_init_r;
  endproperty
  a_zq_first: assert property (p_zq_first) else $error("later long cal marked initial");
endmodule : sdram_command_decoder

// ### sdram_command_decoder_bench.sv
// self-checking bench for the sdram command decoder
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module sdram_command_decoder_bench
  import cmd_decode_pkg::*;
;
  localparam logic [3:0] MRW = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
  localparam logic [3:0] WR = 4'h4, RD = 4'h5, ZQ = 4'h6, NOP = 4'h7, DES = 4'hf;
  logic clk, rst_n, cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [BANK_W-1:0] ba, cmd_bank;
  logic [ADDR_W-1:0] addr, cmd_addr;
  logic [4:0] cmd_code;
  logic cmd_valid, cmd_auto_close, burst_busy, idle, cal_initial, cal_pulse;
  logic [3:0] cmd_burst_len;
  logic [1:0] pwr_state;
  logic [ADDR_W-1:0] mode_reg [MR_COUNT];
  logic [BANK_W:0] open_banks;
  int num_errors = 0;
  int n_tests = 0;

  sdram_command_decoder i_dut (.clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
    .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
    .cmd_auto_close(cmd_auto_close), .cmd_burst_len(cmd_burst_len), .pwr_state(pwr_state),
    .mode_reg(mode_reg), .open_banks(open_banks), .burst_busy(burst_busy), .idle(idle),
    .cal_initial(cal_initial), .cal_pulse(cal_pulse));
  ctl_model i_ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .odt(odt));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wait_burst;
    for (int i = 0; i < 10 && burst_busy === 1'b1; i++) i_ctl.send(NOP);
    `CHK(burst_busy, 1'b0)
  endtask : wait_burst

  task automatic t_cal;
    i_ctl.send(ZQ, 1'b1, 3'h0, 16'h0400);
    `CHK(cmd_code, 5'(cmd_long_impedance_calibration))
    `CHK(cal_initial, 1'b1)
    i_ctl.send(NOP);
    `CHK(cal_pulse, 1'b0)
    i_ctl.send(ZQ, 1'b1, 3'h0, 16'h0400);
    `CHK(cal_initial, 1'b0)
    i_ctl.send(ZQ);
    `CHK(cmd_code, 5'(cmd_short_impedance_calibration))
    `CHK(cal_pulse, 1'b1)
    $display("calibration test done");
  endtask : t_cal

  task automatic t_modes;
    for (int i = 3; i >= 0; i--) begin
      i_ctl.send(MRW, 1'b1, 3'(i), 16'h0a00 | 16'(i));
      `CHK(cmd_code, 5'(cmd_mode_register_write))
      `CHK(mode_reg[i], 16'h0a00 | 16'(i))
      `CHK(cmd_bank, 3'(i))
      `CHK(cmd_addr, 16'h0a00 | 16'(i))
    end
    `CHK(mode_reg[3], 16'h0a03)
    $display("mode register test done");
  endtask : t_modes

  task automatic t_banks;
    i_ctl.send(ACT, 1'b1, 3'h2);
    i_ctl.send(ACT, 1'b1, 3'h3);
    `CHK(open_banks, 4'h2)
    i_ctl.send(PRE, 1'b1, 3'h2);
    `CHK(cmd_code, 5'(cmd_precharge_one))
    `CHK(open_banks, 4'h1)
    i_ctl.send(PRE, 1'b1, 3'h0, 16'h0400);
    `CHK(cmd_code, 5'(cmd_precharge_every_bank))
    i_ctl.send(NOP);
    `CHK(open_banks, 4'h0)
    `CHK(idle, 1'b1)
    $display("bank test done");
  endtask : t_banks

  task automatic t_burst;
    i_ctl.send(ACT, 1'b1, 3'h1, 16'h0010);
    `CHK(open_banks, 4'h1)
    i_ctl.send(RD, 1'b1, 3'h1, 16'h0400);
    `CHK(cmd_code, 5'(cmd_read))
    `CHK(cmd_valid, 1'b1)
    `CHK(cmd_auto_close, 1'b1)
    `CHK(cmd_burst_len, BURST_LEN8)
    i_ctl.send(WR, 1'b1, 3'h1);
    `CHK(cmd_valid, 1'b0)
    `CHK(open_banks, 4'h0)
    i_ctl.send(DES);
    `CHK(burst_busy, 1'b1)
    i_ctl.send(NOP);
    `CHK(burst_busy, 1'b1)
    `CHK(cmd_valid, 1'b0)
    wait_burst();
    $display("burst test done");
  endtask : t_burst

  task automatic t_len;
    i_ctl.send(MRW, 1'b1, 3'h0, 16'h0001);
    i_ctl.send(RD);
    `CHK(cmd_burst_len, BURST_LEN4)
    `CHK(cmd_auto_close, 1'b0)
    wait_burst();
    i_ctl.send(WR, 1'b1, 3'h0, 16'h1000);
    `CHK(cmd_code, 5'(cmd_write))
    `CHK(cmd_burst_len, BURST_LEN8)
    wait_burst();
    i_ctl.send(MRW, 1'b1, 3'h0, 16'h0002);
    i_ctl.send(RD, 1'b1, 3'h0, 16'h1000);
    `CHK(cmd_burst_len, BURST_LEN4)
    wait_burst();
    $display("burst length test done");
  endtask : t_len

  task automatic t_low_power;
    i_ctl.send(NOP, 1'b0);
    `CHK(pwr_state, 2'(st_power_down))
    `CHK(cmd_code, 5'(cmd_power_down_enter))
    // strobes are ignored while cke stays low
    i_ctl.send(ACT, 1'b0, 3'h1);
    `CHK(open_banks, 4'h0)
    `CHK(idle, 1'b0)
    i_ctl.send(NOP, 1'b1);
    `CHK(pwr_state, 2'(st_active))
    i_ctl.send(REF);
    `CHK(cmd_code, 5'(cmd_refresh))
    i_ctl.send(REF, 1'b0);
    `CHK(pwr_state, 2'(st_self_refresh))
    i_ctl.send(DES, 1'b0);
    `CHK(pwr_state, 2'(st_self_refresh))
    i_ctl.send(DES, 1'b1);
    `CHK(pwr_state, 2'(st_active))
    $display("low power test done");
  endtask : t_low_power

  // mid-run reset: mode registers clear and the next long cal is initial again
  task automatic t_reset;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK(mode_reg[0], MR_RESET)
    `CHK(pwr_state, 2'(st_active))
    `CHK(cmd_valid, 1'b0)
    i_ctl.send(ZQ, 1'b1, 3'h0, 16'h0400);
    `CHK(cmd_code, 5'(cmd_long_impedance_calibration))
    `CHK(cal_initial, 1'b1)
    $display("reset test done");
  endtask : t_reset

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  initial begin
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    `CHK(pwr_state, 2'(st_active))
    `CHK(cmd_code, 5'(cmd_deselect))
    `CHK(mode_reg[0], MR_RESET)
    repeat (2) i_ctl.send(NOP);
    t_cal();
    t_modes();
    t_banks();
    t_burst();
    t_len();
    t_low_power();
    t_reset();
    test_done();
  end

  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule : sdram_command_decoder_bench

// ### strobe_decoder.sv
// pure command decode of the strobe pins for an awake device
`timescale 1ns/10ps
module strobe_decoder
  import cmd_decode_pkg::*;
(
  cmd_bus_if.decoder bus // strobes in, command out
);
  wire [3:0] strobes = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
  wire a10 = bus.addr[AP_BIT];

  always_comb begin
    casez (strobes)
      4'b1???: bus.cmd = cmd_deselect;
      4'b0111: bus.cmd = cmd_nop;
      4'b0000: bus.cmd = cmd_mode_register_write;
      4'b0001: bus.cmd = cmd_refresh;
      4'b0010: bus.cmd = a10 ? cmd_precharge_every_bank : cmd_precharge_one;
      4'b0011: bus.cmd = cmd_activate;
      4'b0100: bus.cmd = cmd_write;
      4'b0101: bus.cmd = cmd_read;
      4'b0110: bus.cmd = a10 ? cmd_long_impedance_calibration
                             : cmd_short_impedance_calibration;
      default: bus.cmd = cmd_illegal;
    endcase
  end
endmodule : strobe_decoder
